// ==== rtl/addr_compare.sv ====
// combinational own-address compare with mask and mode select
`timescale 1ns/100ps
module addr_compare (
    // configuration
    input wire logic [addr_match_pkg::ADDR_W-1:0] own_addr,
    input wire logic own_en,
    input wire logic [addr_match_pkg::ADDR_W-1:0] mask,
    input wire logic ten_bit,
    // bus address and result
    input wire logic [addr_match_pkg::ADDR_W-1:0] bus_addr,
    output logic hit
);
    import addr_match_pkg::*;
    logic [ADDR_W-1:0] care;
    always_comb begin
        care = mask;
        if (!ten_bit) begin
            care = mask & SEVEN_KEEP;
        end
        hit = own_en && (((own_addr ^ bus_addr) & care) == '0);
    end
endmodule : addr_compare

// ==== rtl/addr_match.sv ====
// slave own-address slot three, mask, received-address capture, apb access
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module addr_match (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // address phase from the bit engine
    input wire logic addr_valid,
    input wire logic [addr_match_pkg::ADDR_W-1:0] addr_rx,
    // result
    output logic addr_hit,
    output logic ten_bit_mode,
    output logic soft_reset_hold
);
    import addr_match_pkg::*;

    // register select; read and write paths share one decode
    typedef enum logic [2:0] {
        SEL_OWN3 = 3'h0,
        SEL_RXADDR = 3'h1,
        SEL_MASK = 3'h2,
        SEL_CTRL = 3'h3,
        SEL_STATUS = 3'h4,
        SEL_NONE = 3'h7
    } reg_sel_e;

    // unmapped addresses fall to none so one test raises the error
    function automatic reg_sel_e decode_reg(input logic [11:0] addr);
        reg_sel_e dec;
        dec = SEL_NONE;
        if (addr == OFS_OWN3) begin
            dec = SEL_OWN3;
        end else if (addr == OFS_RXADDR) begin
            dec = SEL_RXADDR;
        end else if (addr == OFS_MASK) begin
            dec = SEL_MASK;
        end else if (addr == OFS_CTRL) begin
            dec = SEL_CTRL;
        end else if (addr == OFS_STATUS) begin
            dec = SEL_STATUS;
        end
        return dec;
    endfunction : decode_reg

    typedef struct packed {
        logic [9:0] own_address_value_three;
        logic own_addr_slot_enable;
        logic [9:0] address_mask_field;
        logic [9:0] received_address_field;
        logic hold;
        logic ten;
        logic wr_blocked;
        logic hit;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } state_s;

    state_s cur;
    state_s nxt;
    logic match;
    logic access;
    reg_sel_e sel;

    assign sel = decode_reg(paddr);

    addr_compare u_cmp (
        .own_addr(cur.own_address_value_three),
        .own_en(cur.own_addr_slot_enable),
        .mask(cur.address_mask_field),
        .ten_bit(cur.ten),
        .bus_addr(addr_rx),
        .hit(match)
    );

    assign access = psel && penable && !cur.ready;

    always_comb begin
        nxt = cur;
        nxt.ready = access;
        nxt.err = 1'b0;
        nxt.rdata = RD_ZERO;
        nxt.hit = addr_valid && match;
        // capture real address on hit only
        if (addr_valid && match) begin
            nxt.received_address_field = addr_rx;
        end
        if (access && pwrite) begin
            if (sel == SEL_CTRL) begin
                nxt.hold = pwdata[CTRL_HOLD_BIT];
                nxt.ten = pwdata[CTRL_TEN_BIT];
            end else if (sel == SEL_OWN3 || sel == SEL_MASK) begin
                // config writes honoured only under hold
                if (!cur.hold) begin
                    nxt.wr_blocked = 1'b1;
                    nxt.err = 1'b1;
                end else if (sel == SEL_OWN3) begin
                    nxt.own_address_value_three = pwdata[9:0];
                    nxt.own_addr_slot_enable = pwdata[EN_BIT];
                end else begin
                    nxt.address_mask_field = pwdata[9:0];
                end
            end else if (sel == SEL_STATUS) begin
                // write one clears; a blocked write cannot share the cycle
                nxt.wr_blocked = cur.wr_blocked & ~pwdata[0];
            end else if (sel == SEL_NONE) begin
                nxt.err = 1'b1;
            end
        end else if (access) begin
            // unused upper bits of every word read zero
            if (sel == SEL_OWN3) begin
                nxt.rdata = {21'h0, cur.own_addr_slot_enable,
                             cur.own_address_value_three};
            end else if (sel == SEL_RXADDR) begin
                nxt.rdata = {22'h0, cur.received_address_field};
            end else if (sel == SEL_MASK) begin
                nxt.rdata = {22'h0, cur.address_mask_field};
            end else if (sel == SEL_CTRL) begin
                nxt.rdata = {30'h0, cur.ten, cur.hold};
            end else if (sel == SEL_STATUS) begin
                nxt.rdata = {31'h0, cur.wr_blocked};
            end else begin
                nxt.err = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
            cur.address_mask_field <= MASK_RESET;
            cur.own_address_value_three <= OWN_RESET;
            cur.received_address_field <= RX_RESET;
        end else begin
            cur <= nxt;
        end
    end

    assign prdata = cur.rdata;
    assign pready = cur.ready;
    assign pslverr = cur.err;
    assign addr_hit = cur.hit;
    assign ten_bit_mode = cur.ten;
    assign soft_reset_hold = cur.hold;

    a_disabled_no_hit: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cur.own_addr_slot_enable && !$past(cur.own_addr_slot_enable)
        |-> !addr_hit
    ) else $error("hit from disabled slot");
    a_capture_on_hit: assert property (
        @(posedge pclk) disable iff (!presetn)
        addr_valid && match
        |=> cur.received_address_field == $past(addr_rx)
    ) else $error("matched address not captured");
    a_capture_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(addr_valid && match)
        |=> $stable(cur.received_address_field)
    ) else $error("capture changed without hit");
    a_hit_needs_valid: assert property (
        @(posedge pclk) disable iff (!presetn)
        addr_hit |-> $past(addr_valid)
    ) else $error("hit without address phase");
    a_cfg_locked: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cur.hold |=> $stable(cur.address_mask_field)
    ) else $error("mask changed without hold");
    a_own_locked: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cur.hold |=> $stable(cur.own_address_value_three)
        && $stable(cur.own_addr_slot_enable)
    ) else $error("own slot changed without hold");
    a_blocked_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur.wr_blocked && !(access && pwrite && sel == SEL_STATUS)
        |=> cur.wr_blocked
    ) else $error("blocked-write flag lost");
    a_seven_ignore: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cur.ten && cur.own_addr_slot_enable
        && cur.address_mask_field == MASK_RESET
        && addr_rx[SEVEN_MSB:0] == cur.own_address_value_three[SEVEN_MSB:0]
        |-> match
    ) else $error("seven-bit compare uses upper bits");
    a_ten_exact: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur.ten && cur.address_mask_field == MASK_RESET && match
        |-> addr_rx == cur.own_address_value_three
    ) else $error("ten-bit compare not exact");
    a_mask_dontcare: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur.own_addr_slot_enable && cur.address_mask_field == 10'h000
        |-> match
    ) else $error("cleared mask still compares");
    a_reset_values: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn)
        |-> cur.address_mask_field == MASK_RESET
        && cur.received_address_field == RX_RESET
        && !cur.own_addr_slot_enable
    ) else $error("wrong value after reset");
    a_read_upper_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:11] == '0
    ) else $error("reserved read bits not zero");
    // apb answer after one wait state
    a_apb_ready: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready
    ) else $error("apb answer late");
    // answer lasts one cycle only
    a_ready_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready
    ) else $error("apb answer held too long");
    // error only alongside the answer
    a_err_with_ready: assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready
    ) else $error("error without answer");
endmodule : addr_match

// ==== rtl/addr_match_pkg.sv ====
// package: register map, field layout and reset values of the address matcher
package addr_match_pkg;
    localparam int ADDR_W = 10;
    localparam logic [11:0] OFS_OWN3 = 12'h0000;
    localparam logic [11:0] OFS_RXADDR = 12'h0004;
    localparam logic [11:0] OFS_MASK = 12'h0008;
    localparam logic [11:0] OFS_CTRL = 12'h000c;
    localparam logic [11:0] OFS_STATUS = 12'h0010;
    localparam int EN_BIT = 10;
    localparam int SEVEN_MSB = 6;
    localparam int CTRL_HOLD_BIT = 0;
    localparam int CTRL_TEN_BIT = 1;
    localparam logic [9:0] OWN_RESET = 10'h000;
    localparam logic [9:0] RX_RESET = 10'h000;
    localparam logic [9:0] MASK_RESET = 10'h3ff;
    localparam logic [9:0] SEVEN_KEEP = 10'h07f;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : addr_match_pkg

// ==== verification/addr_master_model.sv ====
// external bus master model handing received addresses to the matcher
`timescale 1ns/100ps
module addr_master_model (
    // clock and address phase
    input wire logic pclk,
    output logic addr_valid,
    output logic [9:0] addr_rx
);
    initial addr_valid = 1'b0;
    initial addr_rx = 10'h000;
    task automatic send(input logic [9:0] a);
        addr_valid <= 1'b1;
        addr_rx <= a;
        @(posedge pclk);
        addr_valid <= 1'b0;
        addr_rx <= ~a; // released bus never shows a stale value
    endtask : send
endmodule : addr_master_model

// ==== verification/i2c_slave_address_match_tb.sv ====
// self-checking bench for the slave address matcher
`timescale 1ns/100ps
module i2c_slave_address_match_tb;
    import addr_match_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, addr_valid, addr_hit;
    logic ten_bit_mode, soft_reset_hold;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [9:0] addr_rx;
    int err_total, total_checks;
    addr_match u_addr_match (.*);
    addr_master_model u_addr_master_model (.*);
    initial forever #5 pclk = ~pclk;
    initial begin
        repeat (3000) @(posedge pclk);
        err_total++;
        tally_and_finish();
    end
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [10:0] d, input logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {21'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        check({pslverr, prdata & {32{!w}}}, {err, 21'h0, d & {11{!w}}});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic hit(input logic [9:0] a, input logic h);
        u_addr_master_model.send(a);
        @(negedge pclk);
        check({32'h0, addr_hit}, {32'h0, h});
        @(posedge pclk);
    endtask : hit
    task automatic t_seven_bit();
        apb(1'b0, OFS_RXADDR, 11'h000, 1'b0);
        apb(1'b0, OFS_MASK, 11'h3ff, 1'b0);
        hit(10'h000, 1'b0);
        apb(1'b1, OFS_CTRL, 11'h001, 1'b0);
        check(33'(soft_reset_hold), 33'h0_0000_0001);
        check(33'(ten_bit_mode), 33'h0_0000_0000);
        apb(1'b1, OFS_OWN3, 11'h3d5, 1'b0);
        hit(10'h055, 1'b0);
        apb(1'b1, OFS_OWN3, 11'h7d5, 1'b0);
        apb(1'b0, OFS_OWN3, 11'h7d5, 1'b0);
        hit(10'h055, 1'b1);
        hit(10'h054, 1'b0);
        apb(1'b0, OFS_RXADDR, 11'h055, 1'b0);
        apb(1'b1, OFS_RXADDR, 11'h3ff, 1'b0);
        apb(1'b0, OFS_RXADDR, 11'h055, 1'b0);
    endtask : t_seven_bit
    task automatic t_ten_bit_and_lock();
        apb(1'b1, OFS_CTRL, 11'h003, 1'b0);
        check(33'(ten_bit_mode), 33'h0_0000_0001);
        hit(10'h055, 1'b0);
        hit(10'h3d5, 1'b1);
        apb(1'b1, OFS_MASK, 11'h1fe, 1'b0);
        hit(10'h1d4, 1'b1);
        hit(10'h2d5, 1'b0);
        apb(1'b0, OFS_RXADDR, 11'h1d4, 1'b0);
        apb(1'b1, OFS_MASK, 11'h000, 1'b0);
        hit(10'h22a, 1'b1);
        apb(1'b0, OFS_RXADDR, 11'h22a, 1'b0);
        apb(1'b1, OFS_CTRL, 11'h002, 1'b0);
        check(33'(soft_reset_hold), 33'h0_0000_0000);
        apb(1'b1, OFS_MASK, 11'h3ff, 1'b1);
        apb(1'b1, OFS_OWN3, 11'h000, 1'b1);
        apb(1'b0, OFS_MASK, 11'h000, 1'b0);
        apb(1'b0, OFS_OWN3, 11'h7d5, 1'b0);
        apb(1'b0, OFS_STATUS, 11'h001, 1'b0);
        apb(1'b1, OFS_STATUS, 11'h001, 1'b0);
        apb(1'b0, OFS_STATUS, 11'h000, 1'b0);
        apb(1'b0, 12'h040, 11'h000, 1'b1);
    endtask : t_ten_bit_and_lock
    task automatic t_reset();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_MASK, 11'h3ff, 1'b0);
        apb(1'b0, OFS_RXADDR, 11'h000, 1'b0);
        apb(1'b0, OFS_OWN3, 11'h000, 1'b0);
        apb(1'b0, OFS_CTRL, 11'h000, 1'b0);
        hit(10'h000, 1'b0);
    endtask : t_reset
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_seven_bit();
        t_ten_bit_and_lock();
        t_reset();
        tally_and_finish();
    end
endmodule : i2c_slave_address_match_tb
